/* logic/crb_rx_buffer.sv */
// CAN receive window, read pointer, error counters and transmit output driver.
// Assumes a protocol engine on the same clock giving one-cycle error and success pulses.
`timescale 1ns/1ps

// Overview of operation
// - Normal output drives bit stream on primary, its inverse on secondary.
// - Clock output keeps bit stream on primary, bit clock copy on secondary.
// - Output mode 10 is normal, 11 is clock output, upper bit 0 reserved.
// - Output config writable only in reset mode; six upper bits read zero.
// - Thirteen-byte read-only window at 10h..1Ch shows head FIFO message in operating mode, zero in reset mode.
// - First window byte is frame information: format, remote flag, length.
// - Standard: two id bytes then data; extended: four id bytes then data.
// - Read pointer holds 0..63; FIFO location 0 at 20h, 63 at 5Fh.
// - Read pointer clears on hardware reset; software reset keeps pointer, FIFO.
// - Software reset loads write pointer from read pointer.
// - Read pointer writable only in reset mode.
// - Receive count +1 on error, +8 on severe errors, -1 on success.
// - Success with receive count above 127 sets it to 119..127.
// - Dominant runs of 14 (or 8 passive) add 8 to both, again each 8.
// - Transmit count +8 on error flag or bit error, -1 on success.
// - Warning interrupt when receive count reaches limit, not if already raised.
// - Receive count above 127 enters passive with interrupt, unless already passive.
// - Receive count clears on hardware reset and on bus-off.
// - Receive count writable in reset mode, ignored at bus-off, effective on leaving.
// - Reset-mode bit set aborts and enters reset; clearing returns to operating.
// - Passive interrupt on any active/passive change, only when enabled.
module crb_rx_buffer
    import crb_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic TX_BIT_I,
    input wire logic TX_BIT_CLOCK_I,
    output logic TX_PRIMARY_OUT_O,
    output logic TX_SECONDARY_OUT_O,
    input wire logic FIFO_WR_I,
    input wire logic [7:0] FIFO_WDATA_I,
    input wire logic RX_ERR_I,
    input wire logic RX_SEVERE_ERR_I,
    input wire logic RX_OK_I,
    input wire logic TX_ERR_FLAG_I,
    input wire logic TX_OK_I,
    input wire logic DOMINANT_BIT_I,
    input wire logic ERR_FLAG_SENT_I,
    input wire logic ERR_FLAG_PASSIVE_I,
    input wire logic BUS_OFF_I,
    output logic RESET_MODE_O,
    output logic WARN_IRQ_O,
    output logic PASSIVE_IRQ_O,
    output logic ERROR_PASSIVE_O
);
    // ********************
    // Storage
    // ********************
    logic [7:0] fifo_mem [CRB_FIFO_DEPTH];
    logic reset_mode_r;
    logic [1:0] out_cfg_r;
    logic [7:0] irq_en_r;
    logic [7:0] warning_limit_r;
    logic [5:0] rd_ptr_r;
    logic [5:0] wr_ptr_r;
    logic [7:0] rx_err_r;
    logic [7:0] rx_err_nxt;
    logic [7:0] rx_err_shadow_r;
    logic rx_err_pending_r;
    logic [7:0] tx_err_r;
    logic [7:0] tx_err_nxt;
    logic [3:0] dom_run_r;
    logic dom_watch_r;
    logic dom_first_r;
    logic dom_passive_r;
    logic [3:0] dom_limit;
    logic dom_step;
    logic passive_r;
    logic warn_r;
    logic [1:0] events_r;
    logic [7:0] rdata_r;
    logic wr_mode;
    logic wr_in_reset;
    logic leave_reset;
    logic warn_now;
    logic passive_now;
    logic [1:0] set_v;
    logic [7:0] win_off;
    logic [5:0] win_idx;

    // Counters stick at FF instead of wrapping back to error active
    function automatic logic [7:0] sat_add(input logic [7:0] v, input logic [7:0] s);
        logic [8:0] sum;
        sum = {1'b0, v} + {1'b0, s};
        return sum[8] ? 8'hff : sum[7:0];
    endfunction

    function automatic logic [7:0] dec_floor(input logic [7:0] v);
        return (v == 8'h00) ? 8'h00 : v - 8'h01;
    endfunction

    assign wr_mode = WR_I && (ADDR_I == CRB_ADDR_MODE);
    assign wr_in_reset = WR_I && reset_mode_r;
    assign leave_reset = wr_mode && reset_mode_r && !WDATA_I[CRB_MODE_RESET_BIT];
    assign RESET_MODE_O = reset_mode_r;

    // ********************
    // Mode and configuration
    // ********************
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            reset_mode_r <= 1'b1;
        end else if (wr_mode) begin
            reset_mode_r <= WDATA_I[CRB_MODE_RESET_BIT];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            out_cfg_r <= CRB_OUT_CFG_RESET;
            irq_en_r <= 8'h00;
            warning_limit_r <= CRB_WARN_LIMIT_RESET;
        end else begin
            if (wr_in_reset && ADDR_I == CRB_ADDR_OUT_CFG) begin
                out_cfg_r <= WDATA_I[1:0];
            end
            if (WR_I && ADDR_I == CRB_ADDR_IRQ_EN) begin
                irq_en_r <= WDATA_I;
            end
            if (wr_in_reset && ADDR_I == CRB_ADDR_WARN_LIMIT) begin
                warning_limit_r <= WDATA_I;
            end
        end
    end

    // ********************
    // Transmit output driver
    // ********************
    always_comb begin
        TX_PRIMARY_OUT_O = TX_BIT_I;
        case (out_cfg_r)
            2'h2: TX_SECONDARY_OUT_O = ~TX_BIT_I;
            2'h3: TX_SECONDARY_OUT_O = TX_BIT_CLOCK_I;
            // Reserved codes fall back to normal output
            default: TX_SECONDARY_OUT_O = ~TX_BIT_I;
        endcase
    end

    // ********************
    // Receive FIFO and pointers
    // ********************
    always_ff @(posedge CLK_I) begin
        // FIFO contents survive every reset
        if (FIFO_WR_I && !reset_mode_r) begin
            fifo_mem[wr_ptr_r] <= FIFO_WDATA_I;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            rd_ptr_r <= CRB_PTR_RESET;
        end else if (wr_in_reset && ADDR_I == CRB_ADDR_RD_PTR) begin
            rd_ptr_r <= WDATA_I[5:0];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            wr_ptr_r <= CRB_PTR_RESET;
        end else if (reset_mode_r) begin
            wr_ptr_r <= rd_ptr_r;
        end else if (FIFO_WR_I) begin
            wr_ptr_r <= wr_ptr_r + 6'h01;
        end
    end

    // ********************
    // Error counters
    // ********************
    // Dominant run after an error flag: first step at 14 (8 if passive), then every 8
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I || reset_mode_r) begin
            dom_watch_r <= 1'b0;
            dom_first_r <= 1'b0;
            dom_passive_r <= 1'b0;
            dom_run_r <= 4'h0;
        end else if (ERR_FLAG_SENT_I) begin
            // A new error flag restarts the run
            dom_watch_r <= 1'b1;
            dom_first_r <= 1'b1;
            dom_passive_r <= ERR_FLAG_PASSIVE_I;
            dom_run_r <= 4'h0;
        end else if (!DOMINANT_BIT_I) begin
            // A recessive bit ends the run
            dom_watch_r <= 1'b0;
            dom_run_r <= 4'h0;
        end else if (dom_watch_r) begin
            dom_run_r <= dom_step ? 4'h0 : dom_run_r + 4'h1;
            if (dom_step) begin
                dom_first_r <= 1'b0;
            end
        end
    end

    // Run length that yields the next step
    assign dom_limit = !dom_first_r ? CRB_NEXT_RUN : (dom_passive_r ? CRB_PASSIVE_RUN : CRB_FIRST_RUN);
    assign dom_step = dom_watch_r && DOMINANT_BIT_I && ((dom_run_r + 4'h1) == dom_limit);

    // Success outranks an error reported in the same cycle
    always_comb begin
        rx_err_nxt = rx_err_r;
        if (RX_OK_I) begin
            // Leaving error passive lands at the bottom of the allowed band
            rx_err_nxt = (rx_err_r > CRB_PASSIVE_LEVEL) ? CRB_RECOVER_VALUE : dec_floor(rx_err_r);
        end else if (RX_SEVERE_ERR_I || dom_step) begin
            rx_err_nxt = sat_add(rx_err_r, CRB_STEP_BIG);
        end else if (RX_ERR_I) begin
            rx_err_nxt = sat_add(rx_err_r, 8'h01);
        end
        tx_err_nxt = tx_err_r;
        if (TX_OK_I) begin
            tx_err_nxt = dec_floor(tx_err_r);
        end else if (TX_ERR_FLAG_I || dom_step) begin
            tx_err_nxt = sat_add(tx_err_r, CRB_STEP_BIG);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I || BUS_OFF_I) begin
            rx_err_r <= 8'h00;
        end else if (leave_reset && rx_err_pending_r) begin
            rx_err_r <= rx_err_shadow_r;
        end else if (!reset_mode_r) begin
            rx_err_r <= rx_err_nxt;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I || BUS_OFF_I || leave_reset) begin
            rx_err_pending_r <= 1'b0;
            rx_err_shadow_r <= 8'h00;
        end else if (wr_in_reset && ADDR_I == CRB_ADDR_RX_ERR) begin
            rx_err_pending_r <= 1'b1;
            rx_err_shadow_r <= WDATA_I;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I || BUS_OFF_I) begin
            tx_err_r <= 8'h00;
        end else if (!reset_mode_r) begin
            tx_err_r <= tx_err_nxt;
        end
    end

    // ********************
    // Warning and passive state
    // ********************
    // Either counter may cause it; a second cause raises nothing new
    assign warn_now = (rx_err_r >= warning_limit_r) || (tx_err_r >= warning_limit_r);
    assign passive_now = (rx_err_r > CRB_PASSIVE_LEVEL) || (tx_err_r > CRB_PASSIVE_LEVEL);

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            passive_r <= 1'b0;
            warn_r <= 1'b0;
        end else begin
            passive_r <= passive_now;
            warn_r <= warn_now;
        end
    end

    assign ERROR_PASSIVE_O = passive_r;

    // Events: bit 0 warning, bit 1 passive; set wins over read-clear
    always_comb begin
        set_v[0] = irq_en_r[CRB_IEN_WARN_BIT] && (warn_r != warn_now);
        set_v[1] = irq_en_r[CRB_IEN_PASSIVE_BIT] && (passive_r != passive_now);
    end

    // A flag read in the cycle of a new event stays set
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            events_r <= 2'b00;
        end else if (RD_I && ADDR_I == CRB_ADDR_EVENTS) begin
            events_r <= set_v;
        end else begin
            events_r <= events_r | set_v;
        end
    end

    assign WARN_IRQ_O = events_r[0];
    assign PASSIVE_IRQ_O = events_r[1];

    // ********************
    // Read port
    // ********************
    // Window offset wraps through the FIFO end
    assign win_off = ADDR_I - CRB_ADDR_WIN_FIRST;
    assign win_idx = rd_ptr_r + win_off[5:0];

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            rdata_r <= 8'h00;
        end else if (RD_I) begin
            rdata_r <= 8'h00;
            if (ADDR_I == CRB_ADDR_MODE) begin
                rdata_r <= {7'h00, reset_mode_r};
            end else if (ADDR_I == CRB_ADDR_STATUS) begin
                rdata_r[CRB_ST_BUS_OFF_BIT] <= BUS_OFF_I;
                rdata_r[CRB_ST_WARN_BIT] <= warn_r;
                rdata_r[CRB_ST_PASSIVE_BIT] <= passive_r;
            end else if (ADDR_I == CRB_ADDR_EVENTS) begin
                rdata_r <= {6'h00, events_r};
            end else if (ADDR_I == CRB_ADDR_IRQ_EN) begin
                rdata_r <= irq_en_r;
            end else if (ADDR_I == CRB_ADDR_OUT_CFG) begin
                rdata_r <= {6'h00, out_cfg_r};
            end else if (ADDR_I == CRB_ADDR_WARN_LIMIT) begin
                rdata_r <= warning_limit_r;
            end else if (ADDR_I == CRB_ADDR_RX_ERR) begin
                rdata_r <= rx_err_r;
            end else if (ADDR_I == CRB_ADDR_TX_ERR) begin
                rdata_r <= tx_err_r;
            end else if (win_off < {3'h0, CRB_WIN_BYTES}) begin
                // Window only in operating mode; frame layout is as written by the receiver
                if (!reset_mode_r) begin
                    rdata_r <= fifo_mem[win_idx];
                end
            end else if (ADDR_I == CRB_ADDR_RD_PTR) begin
                rdata_r <= {2'b00, rd_ptr_r};
            end else if (ADDR_I == CRB_ADDR_WR_PTR) begin
                rdata_r <= {2'b00, wr_ptr_r};
            end else if (ADDR_I >= CRB_ADDR_FIFO_FIRST && ADDR_I <= CRB_ADDR_FIFO_LAST) begin
                rdata_r <= fifo_mem[6'(ADDR_I - CRB_ADDR_FIFO_FIRST)];
            end
        end
    end

    assign RDATA_O = rdata_r;
endmodule // crb_rx_buffer

/* logic/crb_pkg.sv */
// Package for the receive buffer and error counter block: map, fields, resets, counts.
// Assumes byte-wide register port with 8-bit addresses.
package crb_pkg;
    // ********************
    // Register map
    // ********************
    localparam logic [7:0] CRB_ADDR_MODE = 8'h00;
    localparam logic [7:0] CRB_ADDR_IRQ_EN = 8'h04;
    localparam logic [7:0] CRB_ADDR_EVENTS = 8'h03;
    localparam logic [7:0] CRB_ADDR_WARN_LIMIT = 8'h0d;
    localparam logic [7:0] CRB_ADDR_STATUS = 8'h02;
    localparam logic [7:0] CRB_ADDR_OUT_CFG = 8'h08;
    localparam logic [7:0] CRB_ADDR_RX_ERR = 8'h0e;
    localparam logic [7:0] CRB_ADDR_TX_ERR = 8'h0f;
    localparam logic [7:0] CRB_ADDR_WIN_FIRST = 8'h10;
    localparam logic [7:0] CRB_ADDR_WIN_LAST = 8'h1c;
    localparam logic [7:0] CRB_ADDR_RD_PTR = 8'h1e;
    localparam logic [7:0] CRB_ADDR_FIFO_FIRST = 8'h20;
    localparam logic [7:0] CRB_ADDR_FIFO_LAST = 8'h5f;
    localparam logic [7:0] CRB_ADDR_WR_PTR = 8'h1f;
    // ********************
    // Fields and resets
    // ********************
    localparam int CRB_MODE_RESET_BIT = 0;
    localparam int CRB_IEN_WARN_BIT = 2;
    localparam int CRB_IEN_PASSIVE_BIT = 5;
    localparam int CRB_ST_BUS_OFF_BIT = 7;
    localparam int CRB_ST_WARN_BIT = 6;
    localparam int CRB_ST_PASSIVE_BIT = 5;
    localparam logic [1:0] CRB_OUT_CFG_RESET = 2'h2;
    localparam logic [7:0] CRB_WARN_LIMIT_RESET = 8'h60;
    localparam logic [7:0] CRB_PASSIVE_LEVEL = 8'h7f;
    localparam logic [7:0] CRB_RECOVER_VALUE = 8'h77;
    localparam logic [7:0] CRB_STEP_BIG = 8'h08;
    localparam logic [5:0] CRB_PTR_RESET = 6'h00;
    localparam logic [3:0] CRB_FIRST_RUN = 4'he;
    localparam logic [3:0] CRB_PASSIVE_RUN = 4'h8;
    localparam logic [3:0] CRB_NEXT_RUN = 4'h8;
    localparam logic [4:0] CRB_WIN_BYTES = 5'h0d;
    localparam int CRB_FIFO_DEPTH = 64;
endpackage : crb_pkg

/* tb/crb_rx_buffer_assertions.sv */
// Port checker for the receive buffer block.
// Assumes one clock and a synchronous active-low reset; bound to the top module.
`timescale 1ns/1ps
module crb_rx_buffer_chk
    import crb_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic TX_BIT_I,
    input wire logic TX_BIT_CLOCK_I,
    input wire logic TX_PRIMARY_OUT_O,
    input wire logic TX_SECONDARY_OUT_O,
    input wire logic BUS_OFF_I,
    input wire logic RESET_MODE_O,
    input wire logic PASSIVE_IRQ_O,
    input wire logic ERROR_PASSIVE_O
);
    // ********************
    // Properties
    // ********************
    // Output mode as software set it, refused outside reset mode
    logic [1:0] cfg_seen_r;
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            cfg_seen_r <= CRB_OUT_CFG_RESET;
        end else if (WR_I && ADDR_I == CRB_ADDR_OUT_CFG && RESET_MODE_O) begin
            cfg_seen_r <= WDATA_I[1:0];
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    property p_prim; TX_PRIMARY_OUT_O == TX_BIT_I; endproperty
    property p_sec; TX_SECONDARY_OUT_O == ((cfg_seen_r == 2'h3) ? TX_BIT_CLOCK_I : ~TX_BIT_I); endproperty
    property p_mode; WR_I && ADDR_I == CRB_ADDR_MODE |=> RESET_MODE_O == $past(WDATA_I[0]); endproperty
    property p_hold; !(WR_I && ADDR_I == CRB_ADDR_MODE) && !BUS_OFF_I |=> $stable(RESET_MODE_O); endproperty
    property p_cfg; RD_I && ADDR_I == CRB_ADDR_OUT_CFG |=> RDATA_O[7:2] == 6'h00; endproperty
    property p_ptr; RD_I && ADDR_I == CRB_ADDR_RD_PTR |=> RDATA_O[7:6] == 2'h0; endproperty
    property p_win;
        RD_I && ADDR_I >= CRB_ADDR_WIN_FIRST && ADDR_I <= CRB_ADDR_WIN_LAST && RESET_MODE_O |=> RDATA_O == 8'h00;
    endproperty
    // Status lags the counter by one cycle, hence two cycles of bus-off
    property p_boff; BUS_OFF_I ##1 BUS_OFF_I |=> !ERROR_PASSIVE_O; endproperty
    property p_pirq; $rose(PASSIVE_IRQ_O) |-> $changed(ERROR_PASSIVE_O); endproperty
    a_prim: assert property (p_prim) else $error("primary out differs from bit");
    a_sec: assert property (p_sec) else $error("secondary out wrong");
    a_mode: assert property (p_mode) else $error("mode bit not taken");
    a_hold: assert property (p_hold) else $error("mode changed unasked");
    a_cfg: assert property (p_cfg) else $error("cfg upper bits set");
    a_ptr: assert property (p_ptr) else $error("pointer above 63");
    a_win: assert property (p_win) else $error("window open in reset mode");
    a_boff: assert property (p_boff) else $error("passive kept at bus-off");
    a_pirq: assert property (p_pirq) else $error("passive irq without change");
    c_pass: cover property ($rose(ERROR_PASSIVE_O));
    c_leave: cover property ($fell(RESET_MODE_O));
    c_clk: cover property (TX_BIT_CLOCK_I && TX_BIT_I && TX_SECONDARY_OUT_O);
endmodule // crb_rx_buffer_chk

bind crb_rx_buffer crb_rx_buffer_chk u_chk (.CLK_I, .RESET_N_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
    .TX_BIT_I, .TX_BIT_CLOCK_I, .TX_PRIMARY_OUT_O, .TX_SECONDARY_OUT_O, .BUS_OFF_I, .RESET_MODE_O,
    .PASSIVE_IRQ_O, .ERROR_PASSIVE_O);

/* tb/crb_bus_model.sv */
// Line-side source: serial bit stream and one-quantum bit clock.
// Assumes four cycles per bit, changing just after the rising edge.
`timescale 1ns/1ps
module crb_bus_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    output logic tx_bit_o,
    output logic tx_clk_o
);
    localparam logic [7:0] PATTERN = 8'h35;
    logic [4:0] phase_r;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            phase_r <= 5'h00;
        end else begin
            phase_r <= phase_r + 5'h01;
        end
    end
    // Both bit levels meet both clock levels
    assign tx_clk_o = (phase_r[1:0] == 2'h0);
    assign tx_bit_o = PATTERN[phase_r[4:2]];
endmodule // crb_bus_model

/* tb/tb.sv */
// Self-checking bench for the receive buffer block.
// Assumes crb_pkg, the checker and the bus model are compiled first.
`timescale 1ns/1ps
module tb;
    import crb_pkg::*;
    logic CLK_I, RESET_N_I, WR_I, RD_I, FIFO_WR_I, RX_ERR_I, RX_SEVERE_ERR_I, RX_OK_I;
    logic TX_ERR_FLAG_I, TX_OK_I, DOMINANT_BIT_I, ERR_FLAG_SENT_I, ERR_FLAG_PASSIVE_I, BUS_OFF_I;
    logic [7:0] ADDR_I, WDATA_I, FIFO_WDATA_I, RDATA_O;
    logic TX_BIT_I, TX_BIT_CLOCK_I, TX_PRIMARY_OUT_O, TX_SECONDARY_OUT_O;
    logic RESET_MODE_O, WARN_IRQ_O, PASSIVE_IRQ_O, ERROR_PASSIVE_O;
    int n_mismatch = 0;
    int samples_checked = 0;
    crb_rx_buffer uut (.CLK_I, .RESET_N_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .TX_BIT_I,
        .TX_BIT_CLOCK_I, .TX_PRIMARY_OUT_O, .TX_SECONDARY_OUT_O, .FIFO_WR_I, .FIFO_WDATA_I, .RX_ERR_I,
        .RX_SEVERE_ERR_I, .RX_OK_I, .TX_ERR_FLAG_I, .TX_OK_I, .DOMINANT_BIT_I, .ERR_FLAG_SENT_I,
        .ERR_FLAG_PASSIVE_I, .BUS_OFF_I, .RESET_MODE_O, .WARN_IRQ_O, .PASSIVE_IRQ_O, .ERROR_PASSIVE_O);
    crb_bus_model u_bus (.clk_i(CLK_I), .rst_n_i(RESET_N_I), .tx_bit_o(TX_BIT_I), .tx_clk_o(TX_BIT_CLOCK_I));
    initial begin
        CLK_I = 1'b0;
        forever #4 CLK_I = ~CLK_I;
    end
    // ********************
    // Bus and check tasks
    // ********************
    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        ADDR_I <= a;
        WDATA_I <= d;
        WR_I <= 1'b1;
        @(posedge CLK_I);
        WR_I <= 1'b0;
        @(posedge CLK_I);
    endtask
    task rc(input logic [7:0] a, input logic [7:0] e);
        ADDR_I <= a;
        RD_I <= 1'b1;
        @(posedge CLK_I);
        RD_I <= 1'b0;
        @(negedge CLK_I);
        chk(RDATA_O, e);
        @(posedge CLK_I);
    endtask
    task flags(input logic [7:0] e);
        @(negedge CLK_I);
        chk({5'h0, ERROR_PASSIVE_O, PASSIVE_IRQ_O, WARN_IRQ_O}, e);
        @(posedge CLK_I);
    endtask
    // Strobes in order: rx error, rx severe, rx ok, tx error flag, tx ok
    task pulse(input logic [4:0] m, input int n);
        repeat (n) begin
            {RX_ERR_I, RX_SEVERE_ERR_I, RX_OK_I, TX_ERR_FLAG_I, TX_OK_I} <= m;
            @(posedge CLK_I);
            {RX_ERR_I, RX_SEVERE_ERR_I, RX_OK_I, TX_ERR_FLAG_I, TX_OK_I} <= 5'h00;
            @(posedge CLK_I);
        end
    endtask
    function automatic logic [7:0] fb(input int i);
        return (i == 0) ? 8'h08 : 8'ha0 + 8'(i);
    endfunction
    // ********************
    // Scenarios
    // ********************
    task drv(input logic cm);
        repeat (16) begin
            @(negedge CLK_I);
            chk({6'h0, TX_PRIMARY_OUT_O, TX_SECONDARY_OUT_O}, {6'h0, TX_BIT_I, cm ? TX_BIT_CLOCK_I : ~TX_BIT_I});
        end
        @(posedge CLK_I);
    endtask
    task t_outcfg;
        rc(CRB_ADDR_OUT_CFG, 8'h02);
        wr(CRB_ADDR_OUT_CFG, 8'hff);
        rc(CRB_ADDR_OUT_CFG, 8'h03);
        drv(1'b1);
        // Reserved code behaves as normal output
        wr(CRB_ADDR_OUT_CFG, 8'h01);
        rc(CRB_ADDR_OUT_CFG, 8'h01);
        drv(1'b0);
        wr(CRB_ADDR_OUT_CFG, 8'h02);
        drv(1'b0);
        wr(CRB_ADDR_MODE, 8'h00);
        wr(CRB_ADDR_OUT_CFG, 8'h03);
        rc(CRB_ADDR_OUT_CFG, 8'h02);
    endtask
    task t_window;
        for (int i = 0; i < 13; i++) begin
            FIFO_WDATA_I <= fb(i);
            FIFO_WR_I <= 1'b1;
            @(posedge CLK_I);
        end
        FIFO_WR_I <= 1'b0;
        for (int i = 0; i < 13; i++) rc(CRB_ADDR_WIN_FIRST + 8'(i), fb(i));
        rc(CRB_ADDR_FIFO_FIRST + 8'h0c, fb(12));
        wr(CRB_ADDR_MODE, 8'h01);
        rc(CRB_ADDR_WR_PTR, 8'h00);
        rc(CRB_ADDR_FIFO_FIRST, fb(0));
        rc(CRB_ADDR_WIN_FIRST, 8'h00);
        wr(CRB_ADDR_RD_PTR, 8'h3a);
        rc(CRB_ADDR_RD_PTR, 8'h3a);
        wr(CRB_ADDR_MODE, 8'h00);
        wr(CRB_ADDR_RD_PTR, 8'h05);
        rc(CRB_ADDR_RD_PTR, 8'h3a);
        rc(CRB_ADDR_WIN_FIRST + 8'h06, fb(0));
    endtask
    task t_count;
        pulse(5'h10, 3);
        pulse(5'h08, 1);
        pulse(5'h04, 1);
        rc(CRB_ADDR_RX_ERR, 8'h0a);
        pulse(5'h02, 1);
        pulse(5'h01, 1);
        rc(CRB_ADDR_TX_ERR, 8'h07);
        ERR_FLAG_SENT_I <= 1'b1;
        @(posedge CLK_I);
        ERR_FLAG_SENT_I <= 1'b0;
        DOMINANT_BIT_I <= 1'b1;
        // 14th and 22nd dominant bit each add a step
        repeat (22) @(posedge CLK_I);
        DOMINANT_BIT_I <= 1'b0;
        @(posedge CLK_I);
        rc(CRB_ADDR_RX_ERR, 8'h1a);
        rc(CRB_ADDR_TX_ERR, 8'h17);
    endtask
    task t_passive;
        wr(CRB_ADDR_IRQ_EN, 8'h24);
        flags(8'h00);
        pulse(5'h08, 15);
        rc(CRB_ADDR_RX_ERR, 8'h92);
        flags(8'h07);
        rc(CRB_ADDR_STATUS, 8'h60);
        rc(CRB_ADDR_EVENTS, 8'h03);
        flags(8'h04);
        pulse(5'h04, 1);
        rc(CRB_ADDR_RX_ERR, 8'h77);
        // Only the passive change raises a new event; warning level is unchanged
        flags(8'h02);
    endtask
    task t_rxwrite;
        wr(CRB_ADDR_MODE, 8'h01);
        wr(CRB_ADDR_RX_ERR, 8'h40);
        wr(CRB_ADDR_MODE, 8'h00);
        rc(CRB_ADDR_RX_ERR, 8'h40);
        wr(CRB_ADDR_RX_ERR, 8'h10);
        rc(CRB_ADDR_RX_ERR, 8'h40);
        BUS_OFF_I <= 1'b1;
        repeat (2) @(posedge CLK_I);
        rc(CRB_ADDR_RX_ERR, 8'h00);
        wr(CRB_ADDR_MODE, 8'h01);
        wr(CRB_ADDR_RX_ERR, 8'h33);
        BUS_OFF_I <= 1'b0;
        @(posedge CLK_I);
        wr(CRB_ADDR_MODE, 8'h00);
        rc(CRB_ADDR_RX_ERR, 8'h00);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        {ADDR_I, WDATA_I, FIFO_WDATA_I} = '0;
        {WR_I, RD_I, FIFO_WR_I, RX_ERR_I, RX_SEVERE_ERR_I, RX_OK_I} = '0;
        {TX_ERR_FLAG_I, TX_OK_I, DOMINANT_BIT_I, ERR_FLAG_SENT_I, ERR_FLAG_PASSIVE_I, BUS_OFF_I} = '0;
        RESET_N_I = 1'b0;
        repeat (8) @(posedge CLK_I);
        RESET_N_I <= 1'b1;
        rc(CRB_ADDR_RD_PTR, 8'h00);
        rc(CRB_ADDR_RX_ERR, 8'h00);
        t_outcfg();
        t_window();
        t_count();
        t_passive();
        t_rxwrite();
        end_sim();
    end
    // Whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge CLK_I);
        n_mismatch++;
        end_sim();
    end
endmodule // tb
